// ==== hw/dpb_pkg.sv ====
// Package for the double-data-rate pseudo-static memory bus device
package dpb_pkg;

  // ==========================================================
  // Array and command/address layout
  localparam int ADDR_BITS = 8;
  localparam int MEM_WORDS = 256;
  localparam int CA_DIR = 47;
  localparam int CA_SPACE = 46;
  localparam int CA_BURST = 45;
  localparam int CA_UPPER_LO = 16;
  localparam int CA_UPPER_W = 4;
  localparam int CA_CFG_SEL = 24;
  localparam int CA_REG_SEL = 0;
  localparam logic [2:0] CA_LAST_EDGE = 3'h5;

  // ==========================================================
  // Configuration register zero fields and reset values
  localparam int CR0_LAT_LO = 4;
  localparam int CR0_LEN_LO = 0;
  localparam int CR0_LEGACY = 2;
  localparam logic [15:0] CR0_RESET = 16'h0067;
  localparam logic [15:0] CR1_RESET = 16'h0001;
  // Identification values are arbitrary
  localparam logic [15:0] ID0_VALUE = 16'h0A5A;
  localparam logic [15:0] ID1_VALUE = 16'h0003;

  // ==========================================================
  // Software port map
  localparam logic [7:0] SW_CTRL = 8'h00;
  localparam logic [7:0] SW_STATUS = 8'h04;
  localparam logic [7:0] SW_CONFIG = 8'h08;
  localparam logic [31:0] SW_CTRL_RESET = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic cs_n;
    logic ck;
    logic ck_n;
    logic [15:0] dq;
    logic [1:0] mask;
  } dpb_link_in_type;

  typedef struct packed {
    logic [15:0] dq;
    logic dq_oe_n;
    logic [1:0] mask_out;
    logic [1:0] mask_oe_n;
  } dpb_link_out_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dpb_sw_req_type;

  localparam dpb_link_in_type LINK_IDLE = '{cs_n: 1'b1, default: '0};

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_LAT, ST_RDAT, ST_WDAT, ST_REGW, ST_DONE
  } dpb_state_type;

endpackage : dpb_pkg

// ==== hw/dpb_psram_device.sv ====
// Device end of the x16 double-data-rate pseudo-static memory bus
// Summary of operation
// - First three clocks carry a 48-bit command/address as three words.
// - Top command bit chooses direction: one read, zero write.
// - Space bit chooses memory array at zero, register space at one.
// - Burst type comes from the third-highest command bit.
// - Array access may start on row bits; last word picks starting word.
// - Device drives strobe during command: high asks for doubled latency.
// - One latency count is the read latency field of config register zero; a field of zero counts as one.
// - After latency, strobe toggles with read data, each word edge-aligned.
// - Burst runs while clock toggles with select low; select high ends it.
// - Wrapped reads wrap in burst length; linear reads roll over array end.
// - Register read gives high byte first, then low byte, repeating.
// - Upper data lanes are ignored during command cycles.
// - Write words are taken on rising then falling bus clock edges.
// - Mask high leaves the array unchanged; mask low stores the data.
// - Device releases the strobe after command; host drives mask preamble.
// - No extra latency once write data transfer has begun.
// - Hybrid wrap writes wrap once then go linear from next boundary.
// - Linear write past the last array address continues at address zero.
// - Register writes have zero latency; latency indication is disregarded.
// - Zero-latency writes never use the mask; full words are written.
// - Register write: high byte on rising edge, low byte on falling edge.
// - Burst-type bit zero means wrapped, one means linear.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module dpb_psram_device (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Software port
  input wire dpb_pkg::dpb_sw_req_type sw_req,
  output logic [31:0] sw_rdata,
  // Memory bus pins
  input wire dpb_pkg::dpb_link_in_type link_in,
  output dpb_pkg::dpb_link_out_type link_out
);
  import dpb_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [4:0] lat_clocks(input logic [3:0] code);
    lat_clocks = (code == 4'h0) ? 5'h01 : {1'b0, code};
  endfunction : lat_clocks

  function automatic logic [7:0] burst_mask(input logic [1:0] code);
    case (code)
      2'h0: burst_mask = 8'h7F;
      2'h1: burst_mask = 8'h3F;
      2'h2: burst_mask = 8'h0F;
      default: burst_mask = 8'h1F;
    endcase
  endfunction : burst_mask

  function automatic logic [7:0] adv_index(input logic [7:0] a,
                                           input logic wrap,
                                           input logic [7:0] m);
    logic [7:0] inc;
    inc = a + 8'h01;
    adv_index = wrap ? ((a & ~m) | (inc & m)) : inc;
  endfunction : adv_index

  // ==========================================================
  // Pin synchroniser and clock edge finder
  dpb_link_in_type link_m;
  dpb_link_in_type link_s;
  logic ck_d;

  always_ff @(posedge clock) begin
    if (rst) begin
      link_m <= LINK_IDLE;
      link_s <= LINK_IDLE;
      ck_d <= 1'b0;
    end else begin
      link_m <= link_in;
      link_s <= link_m;
      ck_d <= link_s.ck;
    end
  end

  wire logic sel = ~link_s.cs_n;
  wire logic rise_e = sel & link_s.ck & ~ck_d;
  wire logic fall_e = sel & ~link_s.ck & ck_d;
  wire logic any_e = rise_e | fall_e;

  // ==========================================================
  // State and command capture
  dpb_state_type state;
  dpb_state_type next_state;
  logic [2:0] edge_cnt;
  logic [47:0] ca;
  logic [47:0] ca_q;
  logic [4:0] lat_cnt;
  logic read_q;
  logic reg_q;
  logic extra_q;
  logic [15:0] cr0;
  logic [15:0] cr1;
  logic [7:0] reg_hi;
  logic [31:0] ctrl;
  logic [7:0] addr;
  logic [7:0] beats;
  logic [7:0] grp_base;
  logic wrap_on;
  logic hybrid_q;
  logic [15:0] mem [MEM_WORDS];

  // Upper lanes never enter the shift register
  wire logic [47:0] ca_full = {ca[39:0], link_s.dq[7:0]};
  wire logic ca_last = (state == ST_CMD) & any_e &
                       (edge_cnt == CA_LAST_EDGE);
  wire logic ca_is_read = ca_full[CA_DIR];
  wire logic ca_is_reg = ca_full[CA_SPACE];
  wire logic ca_is_lin = ca_full[CA_BURST];
  wire logic start = (state == ST_IDLE) & sel & ~link_s.ck;
  // Row bits sit in the first two words, the start word in the last
  wire logic [7:0] ca_index = {ca_full[CA_UPPER_LO +: CA_UPPER_W],
                               ca_full[2:0], 1'b0};
  wire logic [4:0] lat_unit = lat_clocks(cr0[CR0_LAT_LO +: 4]);
  wire logic [4:0] lat_total = extra_q ? {lat_unit[3:0], 1'b0}
                                       : lat_unit;
  wire logic [7:0] len_mask = burst_mask(cr0[CR0_LEN_LO +: 2]);
  wire logic [7:0] grp_next = grp_base + len_mask + 8'h01;
  wire logic hyb_switch = wrap_on & hybrid_q & (beats == len_mask);
  wire logic [7:0] next_addr = hyb_switch ? grp_next
                               : adv_index(addr, wrap_on, len_mask);
  wire logic [15:0] reg_rd_value = ~ca_q[CA_CFG_SEL]
      ? (ca_q[CA_REG_SEL] ? ID1_VALUE : ID0_VALUE)
      : (ca_q[CA_REG_SEL] ? cr1 : cr0);
  // Register read: high byte on the rising half, low byte on the falling
  wire logic [15:0] rd_word = reg_q
      ? {8'h00, (rise_e ? reg_rd_value[15:8] : reg_rd_value[7:0])}
      : mem[addr];
  wire logic [1:0] mem_we = (state == ST_WDAT && any_e) ? ~link_s.mask
                                                        : 2'b00;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (ca_last) begin
          // Register writes skip latency whatever the strobe said
          next_state = (!ca_is_read && ca_is_reg) ? ST_REGW
                                                  : ST_LAT;
        end
      end
      ST_LAT: begin
        // Latency ends on the falling half of its last clock
        if (fall_e && lat_cnt == 5'h01) begin
          next_state = read_q ? ST_RDAT : ST_WDAT;
        end
      end
      ST_REGW: begin
        if (fall_e) begin
          next_state = ST_DONE;
        end
      end
      default: next_state = state;
    endcase
    if (!sel) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      edge_cnt <= 3'h0;
      lat_cnt <= 5'h00;
    end else begin
      state <= next_state;
      edge_cnt <= (state == ST_CMD && any_e) ? edge_cnt + 3'h1
                  : (state == ST_CMD ? edge_cnt : 3'h0);
      if (ca_last) begin
        lat_cnt <= lat_total;
      end else if (state == ST_LAT && fall_e) begin
        lat_cnt <= lat_cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ca <= 48'h0000_0000_0000;
      ca_q <= 48'h0000_0000_0000;
      read_q <= 1'b0;
      reg_q <= 1'b0;
      extra_q <= 1'b0;
    end else begin
      if (state == ST_CMD && any_e) begin
        ca <= ca_full;
      end
      if (start) begin
        extra_q <= ctrl[0];
      end
      if (ca_last) begin
        ca_q <= ca_full;
        read_q <= ca_is_read;
        reg_q <= ca_is_reg;
      end
    end
  end

  // ==========================================================
  // Burst address walk
  always_ff @(posedge clock) begin
    if (rst) begin
      addr <= 8'h00;
      beats <= 8'h00;
      grp_base <= 8'h00;
      wrap_on <= 1'b0;
      hybrid_q <= 1'b0;
    end else if (ca_last) begin
      addr <= ca_index;
      beats <= 8'h00;
      grp_base <= ca_index & ~len_mask;
      wrap_on <= ~ca_is_lin;
      hybrid_q <= ~cr0[CR0_LEGACY] & ~ca_is_read;
    end else if (any_e && (state == ST_WDAT ||
                           (state == ST_RDAT && !reg_q))) begin
      addr <= next_addr;
      beats <= beats + 8'h01;
      if (hyb_switch) begin
        wrap_on <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Array storage, byte lanes gated by the host mask
  always_ff @(posedge clock) begin
    if (mem_we[0]) begin
      mem[addr][7:0] <= link_s.dq[7:0];
    end
    if (mem_we[1]) begin
      mem[addr][15:8] <= link_s.dq[15:8];
    end
  end

  // ==========================================================
  // Configuration registers, written without latency or mask
  always_ff @(posedge clock) begin
    if (rst) begin
      cr0 <= CR0_RESET;
      cr1 <= CR1_RESET;
      reg_hi <= 8'h00;
    end else if (state == ST_REGW) begin
      if (rise_e) begin
        reg_hi <= link_s.dq[7:0];
      end
      // Mask lane ignored: both bytes land when a config register is selected
      if (fall_e && ca_q[CA_CFG_SEL]) begin
        if (ca_q[CA_REG_SEL]) begin
          cr1 <= {reg_hi, link_s.dq[7:0]};
        end else begin
          cr0 <= {reg_hi, link_s.dq[7:0]};
        end
      end
    end
  end

  // ==========================================================
  // Pin drivers
  // Strobe is held only in command and read phases; writes leave it free
  wire logic drive_mask = (state == ST_CMD) ||
      (read_q && (state == ST_LAT || state == ST_RDAT));

  always_ff @(posedge clock) begin
    if (rst) begin
      link_out <= '{dq: 16'h0000, dq_oe_n: 1'b1, mask_out: 2'b00,
                    mask_oe_n: 2'b11};
    end else begin
      link_out.mask_oe_n <= drive_mask ? 2'b00 : 2'b11;
      // Data lanes turn on with the first strobe edge, not before
      if (state == ST_RDAT && any_e) begin
        link_out.dq_oe_n <= 1'b0;
      end else if (state != ST_RDAT) begin
        link_out.dq_oe_n <= 1'b1;
      end
      if (state == ST_CMD) begin
        link_out.mask_out <= {2{extra_q}};
      end else if (state == ST_RDAT && any_e) begin
        link_out.mask_out <= {2{rise_e}};
        link_out.dq <= rd_word;
      end else if (state != ST_RDAT) begin
        link_out.mask_out <= 2'b00;
      end
    end
  end

  // ==========================================================
  // Software port: control, status, configuration view
  wire logic hit_ctrl = sw_req.addr == SW_CTRL;
  wire logic hit_status = sw_req.addr == SW_STATUS;
  wire logic hit_config = sw_req.addr == SW_CONFIG;
  wire logic [31:0] status_word = {26'h000_0000, wrap_on, reg_q, read_q,
                                   state != ST_IDLE, extra_q, sel};

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= SW_CTRL_RESET;
      sw_rdata <= 32'h0000_0000;
    end else begin
      if (sw_req.wr && hit_ctrl) begin
        ctrl <= {31'h0000_0000, sw_req.wdata[0]};
      end
      if (sw_req.rd) begin
        sw_rdata <= hit_ctrl ? ctrl
                  : hit_status ? status_word
                  : hit_config ? {cr1, cr0}
                  : 32'h0000_0000;
      end else begin
        sw_rdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_ca_read;
    ca_last && ca_is_read;
  endsequence

  sequence s_ca_regw;
    ca_last && !ca_is_read && ca_is_reg && sel;
  endsequence

  chk_dir_decode: assert property (
    s_ca_read |=> state == ST_LAT && read_q)
    else $error("read command did not enter latency as read");

  chk_space_steer: assert property (
    s_ca_regw |=> state == ST_REGW ##1 link_out.mask_oe_n == 2'b11)
    else $error("register write not steered to zero latency");

  chk_burst_kind: assert property (
    ca_last |=> wrap_on == !$past(ca_is_lin))
    else $error("burst type not taken from command");

  chk_cmd_strobe: assert property (
    state == ST_CMD |=> !link_out.mask_oe_n[0] &&
                        link_out.mask_out == {2{extra_q}})
    else $error("strobe not showing latency request in command");

  chk_lat_load: assert property (
    s_ca_read ##0 (cr0[7:4] != 4'h0) |=>
      lat_cnt == (extra_q ? {cr0[7:4], 1'b0} : {1'b0, cr0[7:4]}))
    else $error("latency count mismatch");

  chk_read_edge: assert property (
    state == ST_RDAT && rise_e |=> ##1 link_out.mask_out == 2'b11 &&
                                   !link_out.dq_oe_n)
    else $error("strobe not raised with read data");

  chk_select_end: assert property (
    !sel && state != ST_IDLE |=> state == ST_IDLE)
    else $error("select high did not end burst");

  chk_reg_bytes: assert property (
    state == ST_RDAT && reg_q && fall_e && sel |=>
      link_out.dq[7:0] == $past(reg_rd_value[7:0]))
    else $error("register low byte not on falling half");

  chk_mask_hold: assert property (
    state == ST_WDAT && any_e && link_s.mask[1] |=>
      mem[$past(addr)][15:8] == $past(mem[addr][15:8]))
    else $error("masked byte altered the array");

  chk_write_release: assert property (
    state == ST_LAT && !read_q |=> link_out.mask_oe_n == 2'b11)
    else $error("strobe not released for write");

  chk_linear_end: assert property (
    state == ST_WDAT && any_e && !wrap_on && addr == 8'hFF |=>
      addr == 8'h00)
    else $error("linear write did not roll to address zero");

endmodule : dpb_psram_device

`default_nettype wire

// ==== tb/dpb_host_model.sv ====
// Host controller model that drives the memory bus pins
`timescale 1ns/10ps
`default_nettype none

module dpb_host_model (
  // Clock
  input wire logic clock,
  // Bus pins
  input wire dpb_pkg::dpb_link_out_type link_out,
  output var dpb_pkg::dpb_link_in_type link_in,
  output var logic mask_en
);
  import dpb_pkg::*;

  // ====
  // Data per edge, and what the device showed after each edge
  logic [15:0] tx_dq [0:63];
  logic [1:0] tx_mask [0:63];
  logic [15:0] smp_dq [0:64];
  logic [1:0] smp_mask [0:64];
  logic smp_oe [0:64];
  logic [1:0] smp_moe [0:64];

  initial begin
    link_in = LINK_IDLE;
    link_in.ck_n = 1'b1;
    mask_en = 1'b0;
  end

  // ====
  // One transaction; an even edge count leaves the clock low at the end
  // Sample k shows the device's answer to edge k-1
  task automatic run(input logic [47:0] ca, input int edges,
                     input logic host_mask);
    @(posedge clock);
    link_in.cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int k = 0; k <= edges; k++) begin
      if (k < 6) begin
        link_in.dq <= {8'hA5, ca[47 - 8 * k -: 8]};
      end else if (k < edges) begin
        link_in.dq <= tx_dq[k];
        link_in.mask <= tx_mask[k];
        mask_en <= host_mask;
      end
      @(posedge clock);
      if (k < edges) begin
        link_in.ck <= ~link_in.ck;
        link_in.ck_n <= link_in.ck;
      end
      repeat (3) @(posedge clock);
      smp_dq[k] <= link_out.dq;
      smp_mask[k] <= link_out.mask_out;
      smp_oe[k] <= link_out.dq_oe_n;
      smp_moe[k] <= link_out.mask_oe_n;
    end
    link_in.cs_n <= 1'b1;
    mask_en <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : run

endmodule : dpb_host_model

`default_nettype wire

// ==== tb/dpb_psram_device_tb_top.sv ====
// Self-checking bench for the memory bus device
`timescale 1ns/10ps
`default_nettype none

module dpb_psram_device_tb_top;
  import dpb_pkg::*;

  logic clock = 1'b0;
  logic rst = 1'b1;
  dpb_sw_req_type sw_req = '0;
  logic [31:0] sw_rdata;
  dpb_link_in_type host_pins;
  dpb_link_in_type link_in;
  dpb_link_out_type link_out;
  logic mask_en;
  logic float_bit = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] exp_w [0:7];
  logic [15:0] a_w [0:3];

  always #5 clock = ~clock;
  always @(posedge clock) float_bit <= ~float_bit;

  // ====
  // Strobe wire: device first, then host, else a moving level for high-Z
  always_comb begin
    link_in = host_pins;
    for (int i = 0; i < 2; i++) begin
      if (link_out.mask_oe_n[i] == 1'b0) begin
        link_in.mask[i] = link_out.mask_out[i];
      end else if (!mask_en) begin
        link_in.mask[i] = float_bit ^ i[0];
      end
    end
  end

  dpb_psram_device u_dut (
    .clock(clock),
    .rst(rst),
    .sw_req(sw_req),
    .sw_rdata(sw_rdata),
    .link_in(link_in),
    .link_out(link_out)
  );

  dpb_host_model u_host (
    .clock(clock),
    .link_out(link_out),
    .link_in(host_pins),
    .mask_en(mask_en)
  );

  // ====
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  // ====
  // Software port and bus helpers
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_req.addr <= a;
    sw_req.wdata <= d;
    sw_req.wr <= 1'b1;
    @(posedge clock);
    sw_req.wr <= 1'b0;
  endtask : sw_write

  task automatic sw_check(input logic [7:0] a, input logic [31:0] want);
    @(posedge clock);
    sw_req.addr <= a;
    sw_req.rd <= 1'b1;
    @(posedge clock);
    sw_req.rd <= 1'b0;
    #1 check(sw_rdata, want);
    @(posedge clock);
    #1 check(sw_rdata, 32'h0000_0000);
  endtask : sw_check

  function automatic logic [47:0] ca_of(input logic [2:0] top,
                                        input logic cfg,
                                        input logic [7:0] idx);
    return {top, 13'h0000, 7'h00, cfg, 4'h0, idx[7:4], 13'h0000, idx[3:1]};
  endfunction : ca_of

  // Data from edge first on, n edges; strobe driven in the command, high there only if extra
  task automatic judge(input int first, input int n, input logic regs,
                       input logic extra);
    int s;
    check(u_host.smp_moe[3], 2'b00);
    check(u_host.smp_mask[3], {2{extra}});
    check(u_host.smp_oe[first], 1'b1);
    for (int j = 0; j < n; j++) begin
      s = first + j + 1;
      check(u_host.smp_oe[s], 1'b0);
      check(u_host.smp_mask[s], j[0] ? 2'b00 : 2'b11);
      if (regs) begin
        check(u_host.smp_dq[s][7:0],
              j[0] ? exp_w[j / 2][7:0] : exp_w[j / 2][15:8]);
      end else begin
        check(u_host.smp_dq[s], exp_w[j]);
      end
    end
    check(link_out.dq_oe_n, 1'b1);
    check(link_out.mask_oe_n, 2'b11);
  endtask : judge

  // ====
  // Scenarios
  task automatic t_sw_port();
    sw_check(SW_CONFIG, {CR1_RESET, CR0_RESET});
    sw_check(8'h0C, 32'h0000_0000);
    sw_write(SW_CTRL, 32'hFFFF_FFFF);
    sw_check(SW_CTRL, 32'h0000_0001);
    sw_write(SW_CTRL, 32'h0000_0000);
  endtask : t_sw_port

  task automatic t_read_slow();
    exp_w[0] = CR0_RESET;
    exp_w[1] = CR0_RESET;
    u_host.run(ca_of(3'b110, 1'b1, 8'h00), 22, 1'b0);
    judge(18, 4, 1'b1, 1'b0);
  endtask : t_read_slow

  // Extra latency asked for, yet the register write takes no latency
  task automatic t_reg_write();
    sw_write(SW_CTRL, 32'h0000_0001);
    u_host.tx_dq[6] = 16'h5A00;
    u_host.tx_dq[7] = 16'h5A17;
    u_host.run(ca_of(3'b011, 1'b1, 8'h00), 8, 1'b0);
    check(u_host.smp_mask[3], 2'b11);
    sw_check(SW_CONFIG, {CR1_RESET, 16'h0017});
    exp_w[0] = 16'h0017;
    u_host.run(ca_of(3'b110, 1'b1, 8'h00), 12, 1'b0);
    judge(10, 2, 1'b1, 1'b1);
    sw_write(SW_CTRL, 32'h0000_0000);
  endtask : t_reg_write

  task automatic t_reg_reads();
    logic [15:0] vals [0:3];
    vals = '{ID0_VALUE, ID1_VALUE, 16'h0017, CR1_RESET};
    for (int r = 0; r < 4; r++) begin
      exp_w[0] = vals[r];
      u_host.run(ca_of(3'b110, r[1], {6'h00, r[0], 1'b0}), 10, 1'b0);
      judge(8, 2, 1'b1, 1'b0);
    end
  endtask : t_reg_reads

  // Linear write across the array end, masked overwrite, read back
  task automatic t_mem();
    u_host.tx_mask[6] = 2'b00;
    u_host.tx_mask[7] = 2'b00;
    for (int j = 0; j < 4; j++) begin
      a_w[j] = {8'hA0 + 8'(j), 8'h50 + 8'(j)};
      u_host.tx_dq[8 + j] = a_w[j];
      u_host.tx_mask[8 + j] = 2'b00;
    end
    u_host.run(ca_of(3'b001, 1'b0, 8'hFE), 12, 1'b1);
    check(u_host.smp_moe[8], 2'b11);
    u_host.tx_dq[8] = 16'hB0B0;
    u_host.tx_dq[9] = 16'hB1B1;
    u_host.tx_mask[8] = 2'b11;
    u_host.tx_mask[9] = 2'b01;
    u_host.run(ca_of(3'b001, 1'b0, 8'h00), 10, 1'b1);
    exp_w[0] = a_w[0];
    exp_w[1] = a_w[1];
    exp_w[2] = a_w[2];
    exp_w[3] = {8'hB1, a_w[3][7:0]};
    u_host.run(ca_of(3'b101, 1'b0, 8'hFE), 12, 1'b0);
    judge(8, 4, 1'b0, 1'b0);
  endtask : t_mem

  // Wrapped write and read across the top of a 32-word group
  task automatic t_wrap();
    for (int j = 0; j < 4; j++) begin
      exp_w[j] = {8'hC0 + 8'(j), 8'h3C + 8'(j)};
      u_host.tx_dq[8 + j] = exp_w[j];
      u_host.tx_mask[8 + j] = 2'b00;
    end
    u_host.run(ca_of(3'b000, 1'b0, 8'hFE), 12, 1'b1);
    u_host.run(ca_of(3'b100, 1'b0, 8'hFE), 12, 1'b0);
    judge(8, 4, 1'b0, 1'b0);
    sw_check(SW_STATUS, 32'h0000_0028);
    exp_w[0] = exp_w[2];
    exp_w[1] = exp_w[3];
    u_host.run(ca_of(3'b101, 1'b0, 8'hE0), 10, 1'b0);
    judge(8, 2, 1'b0, 1'b0);
  endtask : t_wrap

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    t_sw_port();
    t_read_slow();
    t_reg_write();
    t_reg_reads();
    t_mem();
    t_wrap();
    close_out();
  end

endmodule : dpb_psram_device_tb_top

`default_nettype wire
